//--- rtl/glrs_pkg.sv
// Package: constants, types and register map of the remote/local and status block
//
// Functional notes
// RULE_01 - Addressed indicator lit when talk or listen addressed
// RULE_02 - Lockout moves local to armed, remote to locked
// RULE_03 - Lockout takes effect only after a further command
// RULE_04 - Enable moves local to remote, armed on address
// RULE_05 - Enable false forces and holds plain local
// RULE_06 - Enable change does not alter running message
// RULE_07 - Go-to-local when listen addressed; current message unaffected
// RULE_08 - Panel setting request leaves remote; pending commands error
// RULE_09 - Display-only panel controls leave state untouched
// RULE_10 - Settings kept across every state change
// RULE_11 - Remote indicator lit in remote or remote-locked
// RULE_12 - Local states execute queries only, reject others
// RULE_13 - Armed state: local request never blocks remote
// RULE_14 - Remote executes all commands, updates panel
// RULE_15 - Remote-locked ignores panel local request
// RULE_16 - Serial poll byte bit weight 64 on request
// RULE_17 - Status byte weight 128 always zero
// RULE_18 - Weight 32 abnormal event, weight 16 busy
// RULE_19 - Normal codes: power-up 65, user request 67
// RULE_20 - Abnormal codes 97, 98, 99
// RULE_21 - Pending requests stacked; device clear empties stack
// RULE_22 - Status readable whatever the request enable
// RULE_23 - Error display held until button or command
// RULE_24 - Memory failure restores address 25, end-only terminator
// RULE_25 - Event query returns numeric event code
// RULE_26 - Device clear drops events except power-on
// RULE_27 - Two-bit state register, reset to plain local
package glrs_pkg;
   typedef enum logic [1:0] {
      plain_local_state,
      local_lockout_armed_state,
      plain_remote_state,
      remote_locked_state
   } glrs_rl_t;

   typedef enum logic [1:0] {
      CMD_QUERY,
      CMD_SETTING,
      CMD_OPERATIONAL
   } glrs_cmd_kind_t;

   typedef struct packed {
      logic start;
      glrs_cmd_kind_t kind;
   } glrs_cmd_t;

   typedef struct packed {
      logic powerOn;
      logic idUser;
      logic cmdErr;
      logic execErr;
      logic sysErr;
   } glrs_evt_t;

   // Status byte class codes and flag weights
   localparam logic [7:0] SB_POWER_UP = 8'h41;
   localparam logic [7:0] SB_ID_USER = 8'h43;
   localparam logic [7:0] SB_INVALID_CMD = 8'h61;
   localparam logic [7:0] SB_SETTINGS_ERR = 8'h62;
   localparam logic [7:0] SB_SYSTEM_ERR = 8'h63;
   localparam logic [7:0] SB_BUSY = 8'h10;
   localparam logic [7:0] SB_NONE = 8'h00;

   // Event query codes
   localparam logic [15:0] EQ_NONE = 16'h0000;
   localparam logic [15:0] EQ_POWER_ON = 16'h0191;
   localparam logic [15:0] EQ_ID_USER = 16'h0193;
   localparam logic [15:0] EQ_CMD_ERR = 16'h0065;
   localparam logic [15:0] EQ_EXEC_ERR = 16'h00CD;
   localparam logic [15:0] EQ_SYS_ERR = 16'h012E;

   // Register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_EVCODE = 4'h8;

   // Control register fields and reset values
   localparam int CTRL_SRE_BIT = 0;
   localparam int CTRL_ADDR_LSB = 8;
   localparam int CTRL_EOI_BIT = 16;
   localparam logic [4:0] BUS_ADDR_DEFAULT = 5'h19;
   localparam logic EOI_ONLY_DEFAULT = 1'b1;
   localparam logic SRE_RESET = 1'b0;

   // Status register fields
   localparam int STAT_RL_LSB = 0;
   localparam int STAT_REM_BIT = 2;
   localparam int STAT_ADR_BIT = 3;
   localparam int STAT_SRQ_BIT = 4;
   localparam int STAT_ERRSHOW_BIT = 5;
   localparam int STAT_LLOPEND_BIT = 6;
   localparam int STAT_SB_LSB = 8;

   localparam int STACK_DEPTH = 4;
endpackage

//--- rtl/glrs_stack.sv
// Last-in first-out stack of pending service-request status bytes
`timescale 1ns/1ps
module glrs_stack #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Control
   input wire logic push,
   input wire logic [WIDTH-1:0] pushData,
   input wire logic pop,
   input wire logic clear,
   // State
   output logic [WIDTH-1:0] top,
   output logic empty,
   output logic [$clog2(DEPTH+1)-1:0] count
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [$clog2(DEPTH+1)-1:0] cnt;
   } glrs_stk_t;

   glrs_stk_t s_q, s_d;
   localparam logic [$clog2(DEPTH+1)-1:0] FULL = ($clog2(DEPTH+1))'(DEPTH);

   always_comb begin
      s_d = s_q;
      if (clear) begin
         s_d.cnt = '0;
      end else if (push && pop && s_q.cnt != '0) begin
         s_d.mem[s_q.cnt - 1'b1] = pushData;
      end else if (push) begin
         // A full stack keeps its oldest requests and drops the newest
         if (s_q.cnt != FULL) begin
            s_d.mem[s_q.cnt] = pushData;
            s_d.cnt = s_q.cnt + 1'b1;
         end
      end else if (pop && s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign empty = (s_q.cnt == '0);
   assign count = s_q.cnt;
   assign top = empty ? '0 : s_q.mem[s_q.cnt - 1'b1];

   stack_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
      clear |=> empty) else $error("stack not empty after clear"); // [RULE_21]
endmodule // glrs_stack

//--- rtl/glrs_top.sv
// Remote/local state machine, command gating and serial poll status with AHB-Lite registers
`timescale 1ns/1ps
module glrs_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Bus interface messages
   input wire logic remoteEnable,
   input wire logic lockoutMsg,
   input wire logic goLocalMsg,
   input wire logic listenAddrRcvd,
   input wire logic listenAddressed,
   input wire logic talkAddressed,
   input wire logic deviceClear,
   // Message processor
   input wire glrs_pkg::glrs_cmd_t cmd,
   input wire logic cmdsPending,
   input wire logic procBusy,
   output logic cmdExecute,
   output logic cmdReject,
   // Front panel
   input wire logic panelLocalReq,
   input wire logic panelDisplayPress,
   input wire logic panelButton,
   output logic bus_addressed_indicator,
   output logic remote_indicator,
   output logic errorDisplay,
   // Events and status
   input wire glrs_pkg::glrs_evt_t evt,
   input wire logic nvramFail,
   input wire logic pollStrobe,
   input wire logic errQueryStrobe,
   output logic serviceRequest,
   output logic [7:0] poll_status_byte,
   output logic [15:0] eventCode,
   output logic [4:0] busAddress,
   output logic eoiOnly
);
   typedef struct packed {
      glrs_pkg::glrs_rl_t rl;
      logic lloPend;
      logic powerOnPend;
      logic errShown;
      logic rtlPrev;
      logic service_request_enable;
      logic [4:0] busAddr;
      logic eoiOnly;
      logic addressed;
      logic exec;
      logic reject;
      logic [7:0] sb;
      logic [15:0] code;
      logic dataPhase;
      logic dpWrite;
      logic [3:0] dpAddr;
      logic [31:0] rdata;
   } glrs_state_t;

   glrs_state_t s_q, s_d;

   logic stkPush;
   logic [7:0] stkPushData;
   logic stkPop;
   logic [7:0] stkTop;
   logic stkEmpty;
   logic [2:0] stkCount;
   logic rtlRise;
   logic cmdAllowed;
   logic furtherCmd;
   logic [7:0] headByte;
   logic [15:0] headCode;
   logic addrPhase;
   logic [31:0] ctrlWord;
   logic [31:0] statWord;

   glrs_stack #(
      .WIDTH(8),
      .DEPTH(glrs_pkg::STACK_DEPTH)
   ) u_stack (
      .clock(clock),
      .rst_b(rst_b),
      .push(stkPush),
      .pushData(stkPushData),
      .pop(stkPop),
      .clear(deviceClear), // [RULE_21]
      .top(stkTop),
      .empty(stkEmpty),
      .count(stkCount)
   );

   // Power-on is held outside the stack so that a device clear spares it
   always_comb begin
      if (s_q.powerOnPend) begin
         headByte = glrs_pkg::SB_POWER_UP; // [RULE_19]
      end else begin
         headByte = stkTop;
      end
      if (s_q.powerOnPend) begin
         headCode = glrs_pkg::EQ_POWER_ON;
      end else if (headByte == glrs_pkg::SB_ID_USER) begin
         headCode = glrs_pkg::EQ_ID_USER;
      end else if (headByte == glrs_pkg::SB_INVALID_CMD) begin
         headCode = glrs_pkg::EQ_CMD_ERR;
      end else if (headByte == glrs_pkg::SB_SETTINGS_ERR) begin
         headCode = glrs_pkg::EQ_EXEC_ERR;
      end else if (headByte == glrs_pkg::SB_SYSTEM_ERR) begin
         headCode = glrs_pkg::EQ_SYS_ERR;
      end else begin
         headCode = glrs_pkg::EQ_NONE;
      end
   end

   assign rtlRise = panelLocalReq && !s_q.rtlPrev;
   assign furtherCmd = cmd.start || listenAddrRcvd;
   // Gating uses the state seen when the command starts, so a later change cannot alter it
   assign cmdAllowed = (cmd.kind == glrs_pkg::CMD_QUERY) ||
      (s_q.rl == glrs_pkg::plain_remote_state) ||
      (s_q.rl == glrs_pkg::remote_locked_state); // [RULE_06] [RULE_07] [RULE_12] [RULE_14]

   // One error is queued per cycle; the most severe source wins
   always_comb begin
      stkPush = 1'b1;
      if (evt.sysErr) begin
         stkPushData = glrs_pkg::SB_SYSTEM_ERR; // [RULE_20]
      end else if (evt.execErr || (cmd.start && !cmdAllowed) || (rtlRise && cmdsPending &&
                   s_q.rl == glrs_pkg::plain_remote_state)) begin
         stkPushData = glrs_pkg::SB_SETTINGS_ERR; // [RULE_08] [RULE_12] [RULE_20]
      end else if (evt.cmdErr) begin
         stkPushData = glrs_pkg::SB_INVALID_CMD; // [RULE_20]
      end else if (evt.idUser) begin
         stkPushData = glrs_pkg::SB_ID_USER; // [RULE_19]
      end else begin
         stkPush = 1'b0;
         stkPushData = glrs_pkg::SB_NONE;
      end
   end

   assign stkPop = (pollStrobe || errQueryStrobe) && !s_q.powerOnPend;
   assign addrPhase = hsel && htrans[1] && hready;

   always_comb begin
      ctrlWord = '0;
      ctrlWord[glrs_pkg::CTRL_SRE_BIT] = s_q.service_request_enable;
      ctrlWord[glrs_pkg::CTRL_ADDR_LSB +: 5] = s_q.busAddr;
      ctrlWord[glrs_pkg::CTRL_EOI_BIT] = s_q.eoiOnly;
      statWord = '0;
      statWord[glrs_pkg::STAT_RL_LSB +: 2] = s_q.rl;
      statWord[glrs_pkg::STAT_REM_BIT] = remote_indicator;
      statWord[glrs_pkg::STAT_ADR_BIT] = s_q.addressed;
      statWord[glrs_pkg::STAT_SRQ_BIT] = serviceRequest;
      statWord[glrs_pkg::STAT_ERRSHOW_BIT] = s_q.errShown;
      statWord[glrs_pkg::STAT_LLOPEND_BIT] = s_q.lloPend;
      statWord[glrs_pkg::STAT_SB_LSB +: 8] = s_q.sb;
   end

   always_comb begin
      s_d = s_q;
      s_d.rtlPrev = panelLocalReq;
      s_d.addressed = listenAddressed || talkAddressed; // [RULE_01]
      s_d.exec = cmd.start && cmdAllowed;
      s_d.reject = cmd.start && !cmdAllowed; // [RULE_12]

      // Remote/local transitions; settings fields are never touched here
      if (!remoteEnable) begin
         s_d.rl = glrs_pkg::plain_local_state; // [RULE_05] [RULE_10]
         s_d.lloPend = 1'b0;
      end else begin
         if (lockoutMsg) begin
            s_d.lloPend = 1'b1;
         end
         case (s_q.rl)
            glrs_pkg::plain_local_state: begin
               if (s_q.lloPend && furtherCmd) begin
                  s_d.rl = glrs_pkg::local_lockout_armed_state; // [RULE_02] [RULE_03]
                  s_d.lloPend = lockoutMsg;
               end else if (!panelLocalReq) begin
                  s_d.rl = glrs_pkg::plain_remote_state; // [RULE_04]
               end
            end
            glrs_pkg::local_lockout_armed_state: begin
               if (listenAddrRcvd) begin
                  s_d.rl = glrs_pkg::remote_locked_state; // [RULE_04] [RULE_13]
               end
            end
            glrs_pkg::plain_remote_state: begin
               if (goLocalMsg && listenAddressed) begin
                  s_d.rl = glrs_pkg::plain_local_state; // [RULE_07]
               end else if (s_q.lloPend && furtherCmd) begin
                  s_d.rl = glrs_pkg::remote_locked_state; // [RULE_02] [RULE_03]
                  s_d.lloPend = lockoutMsg;
               end else if (panelLocalReq) begin
                  s_d.rl = glrs_pkg::plain_local_state; // [RULE_08]
               end
            end
            default: begin
               // Panel local request has no effect in the locked state
               if (goLocalMsg && listenAddressed) begin
                  s_d.rl = glrs_pkg::local_lockout_armed_state; // [RULE_07] [RULE_15]
               end
            end
         endcase
      end

      // Power-on event survives device clear and leaves on poll or query
      if (evt.powerOn) begin
         s_d.powerOnPend = 1'b1; // [RULE_26]
      end else if (pollStrobe || errQueryStrobe) begin
         s_d.powerOnPend = 1'b0;
      end

      // Status byte is built whatever the request enable says
      s_d.sb = headByte | (procBusy ? glrs_pkg::SB_BUSY : glrs_pkg::SB_NONE); // [RULE_16] [RULE_18] [RULE_22]
      s_d.sb[7] = 1'b0; // [RULE_17]
      if (errQueryStrobe) begin
         s_d.code = headCode; // [RULE_25]
      end

      // A new error wins over a button press in the same cycle
      if (evt.sysErr || evt.execErr || evt.cmdErr || s_d.reject) begin
         s_d.errShown = 1'b1; // [RULE_23]
      end else if (panelButton || panelDisplayPress || s_q.exec) begin // [RULE_09]
         s_d.errShown = 1'b0; // [RULE_23]
      end

      if (nvramFail) begin
         s_d.busAddr = glrs_pkg::BUS_ADDR_DEFAULT; // [RULE_24]
         s_d.eoiOnly = 1'b1; // [RULE_24]
      end

      // AHB-Lite: zero wait states, read data registered at the address phase
      if (s_q.dataPhase && s_q.dpWrite && !nvramFail && s_q.dpAddr == glrs_pkg::REG_CTRL) begin
         s_d.service_request_enable = hwdata[glrs_pkg::CTRL_SRE_BIT];
         s_d.busAddr = hwdata[glrs_pkg::CTRL_ADDR_LSB +: 5];
         s_d.eoiOnly = hwdata[glrs_pkg::CTRL_EOI_BIT];
      end
      s_d.dataPhase = addrPhase;
      s_d.dpWrite = hwrite;
      s_d.dpAddr = haddr[3:0];
      if (addrPhase && !hwrite) begin
         if (haddr[3:0] == glrs_pkg::REG_CTRL) begin
            s_d.rdata = ctrlWord;
         end else if (haddr[3:0] == glrs_pkg::REG_STATUS) begin
            s_d.rdata = statWord;
         end else if (haddr[3:0] == glrs_pkg::REG_EVCODE) begin
            s_d.rdata = {16'h0000, s_q.code};
         end else begin
            s_d.rdata = '0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         s_q <= '0;
         s_q.rl <= glrs_pkg::plain_local_state; // [RULE_27]
         s_q.service_request_enable <= glrs_pkg::SRE_RESET;
         s_q.busAddr <= glrs_pkg::BUS_ADDR_DEFAULT;
         s_q.eoiOnly <= glrs_pkg::EOI_ONLY_DEFAULT;
      end else begin
         s_q <= s_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign cmdExecute = s_q.exec; // [RULE_14]
   assign cmdReject = s_q.reject;
   assign bus_addressed_indicator = s_q.addressed;
   assign remote_indicator = (s_q.rl == glrs_pkg::plain_remote_state) ||
      (s_q.rl == glrs_pkg::remote_locked_state); // [RULE_11]
   assign errorDisplay = s_q.errShown;
   assign serviceRequest = s_q.service_request_enable && (s_q.powerOnPend || !stkEmpty);
   assign poll_status_byte = s_q.sb;
   assign eventCode = s_q.code;
   assign busAddress = s_q.busAddr;
   assign eoiOnly = s_q.eoiOnly;

   sequence lloArmed_s;
      remoteEnable && lockoutMsg && !furtherCmd;
   endsequence
   sequence lloApplied_s;
      remoteEnable && furtherCmd && !goLocalMsg;
   endsequence

   ren_false_a: assert property (@(posedge clock) disable iff (!rst_b)
      !remoteEnable |=> s_q.rl == glrs_pkg::plain_local_state) else $error("not local with enable false"); // [RULE_05]
   lockout_delay_a: assert property (@(posedge clock) disable iff (!rst_b)
      (s_q.rl == glrs_pkg::plain_remote_state && s_q.lloPend) ##0 lloApplied_s
      |=> s_q.rl == glrs_pkg::remote_locked_state) else $error("lockout not applied"); // [RULE_03]
   lockout_wait_a: assert property (@(posedge clock) disable iff (!rst_b)
      (s_q.rl == glrs_pkg::plain_remote_state && !s_q.lloPend && !panelLocalReq && !goLocalMsg) ##0 lloArmed_s
      |=> s_q.rl == glrs_pkg::plain_remote_state) else $error("lockout applied without command"); // [RULE_02]
   addr_ind_a: assert property (@(posedge clock) disable iff (!rst_b)
      (listenAddressed || talkAddressed) |=> bus_addressed_indicator) else $error("addressed indicator dark"); // [RULE_01]
   remote_ind_a: assert property (@(posedge clock) disable iff (!rst_b)
      remote_indicator == s_q.rl[1]) else $error("remote indicator wrong"); // [RULE_11]
   local_reject_a: assert property (@(posedge clock) disable iff (!rst_b)
      (cmd.start && cmd.kind != glrs_pkg::CMD_QUERY && !s_q.rl[1]) |=> cmdReject && !cmdExecute)
      else $error("command executed in local"); // [RULE_12]
   locked_panel_a: assert property (@(posedge clock) disable iff (!rst_b)
      (s_q.rl == glrs_pkg::remote_locked_state && remoteEnable && !goLocalMsg) |=> remote_indicator)
      else $error("locked state left by panel"); // [RULE_15]
   top_bit_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
      !poll_status_byte[7]) else $error("status byte top bit set"); // [RULE_17]
   busy_bit_a: assert property (@(posedge clock) disable iff (!rst_b)
      procBusy |=> poll_status_byte[4]) else $error("busy bit missing"); // [RULE_18]
   power_sb_a: assert property (@(posedge clock) disable iff (!rst_b)
      evt.powerOn ##1 !procBusy |=> poll_status_byte == glrs_pkg::SB_POWER_UP)
      else $error("power-up code wrong"); // [RULE_19]
   // Listen address locks the armed state even while the panel asks for local
   armed_locked_a: assert property (@(posedge clock) disable iff (!rst_b)
      (s_q.rl == glrs_pkg::local_lockout_armed_state && remoteEnable && listenAddrRcvd)
      |=> s_q.rl == glrs_pkg::remote_locked_state) else $error("armed state not locked"); // [RULE_13]
   power_kept_a: assert property (@(posedge clock) disable iff (!rst_b)
      (deviceClear && s_q.powerOnPend && !pollStrobe && !errQueryStrobe) |=> s_q.powerOnPend)
      else $error("power-on lost on clear"); // [RULE_26]
   stack_bound_a: assert property (@(posedge clock) disable iff (!rst_b)
      stkCount <= 3'(glrs_pkg::STACK_DEPTH)) else $error("stack count beyond depth"); // [RULE_21]
   error_show_a: assert property (@(posedge clock) disable iff (!rst_b)
      evt.sysErr |=> errorDisplay) else $error("error display not set"); // [RULE_23]
   nvram_dflt_a: assert property (@(posedge clock) disable iff (!rst_b)
      nvramFail |=> busAddress == glrs_pkg::BUS_ADDR_DEFAULT && eoiOnly) else $error("defaults not restored"); // [RULE_24]
endmodule // glrs_top

//--- verif/glrs_ctrl_model.sv
// Bus controller model: turns bench requests into interface message pulses and levels
`timescale 1ns/1ps
module glrs_ctrl_model (
   // Clock
   input wire logic clock,
   // Requests from the bench: 1 lockout, 2 go-local, 3 listen address, 4 clear, 5 poll, 6 query
   input wire logic [3:0] op,
   input wire logic renLevel,
   input wire logic [1:0] adLevel,
   // Interface messages
   output logic remoteEnable = 1'b0,
   output logic lockoutMsg = 1'b0,
   output logic goLocalMsg = 1'b0,
   output logic listenAddrRcvd = 1'b0,
   output logic listenAddressed = 1'b0,
   output logic talkAddressed = 1'b0,
   output logic deviceClear = 1'b0,
   output logic pollStrobe = 1'b0,
   output logic errQueryStrobe = 1'b0
);
   // Everything leaves on a clock edge, as a real talker would, never mid-cycle
   always @(posedge clock) begin
      remoteEnable <= renLevel;
      listenAddressed <= adLevel[0];
      talkAddressed <= adLevel[1];
      lockoutMsg <= (op == 4'h1);
      goLocalMsg <= (op == 4'h2);
      listenAddrRcvd <= (op == 4'h3);
      deviceClear <= (op == 4'h4);
      pollStrobe <= (op == 4'h5);
      errQueryStrobe <= (op == 4'h6);
   end
endmodule // glrs_ctrl_model

//--- verif/glrs_top_bench.sv
// Self-checking bench for the remote/local state and status block
`timescale 1ns/1ps
module glrs_top_bench;
   logic clock, rst_b, hsel, hwrite, hreadyout, hresp, renLevel, cmdsPending, procBusy;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, adLevel;
   logic [3:0] op;
   logic remoteEnable, lockoutMsg, goLocalMsg, listenAddrRcvd, listenAddressed, talkAddressed;
   logic deviceClear, pollStrobe, errQueryStrobe, cmdExecute, cmdReject, panelLocalReq;
   logic panelDisplayPress, panelButton, bus_addressed_indicator, remote_indicator, errorDisplay;
   logic nvramFail, serviceRequest, eoiOnly;
   logic [7:0] poll_status_byte;
   logic [15:0] eventCode;
   logic [4:0] busAddress;
   glrs_pkg::glrs_cmd_t cmd;
   glrs_pkg::glrs_evt_t evt;
   int fail_count = 0;
   int total_checks = 0;

   glrs_ctrl_model i_ctrl (.clock, .op, .renLevel, .adLevel, .remoteEnable, .lockoutMsg, .goLocalMsg,
      .listenAddrRcvd, .listenAddressed, .talkAddressed, .deviceClear, .pollStrobe, .errQueryStrobe);

   glrs_top i_dut (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .remoteEnable, .lockoutMsg, .goLocalMsg,
      .listenAddrRcvd, .listenAddressed, .talkAddressed, .deviceClear, .cmd, .cmdsPending, .procBusy,
      .cmdExecute, .cmdReject, .panelLocalReq, .panelDisplayPress, .panelButton, .bus_addressed_indicator,
      .remote_indicator, .errorDisplay, .evt, .nvramFail, .pollStrobe, .errQueryStrobe, .serviceRequest,
      .poll_status_byte, .eventCode, .busAddress, .eoiOnly);

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // The slave is zero-wait today, but the master must not rely on that
   task automatic waitRdy;
      int n;
      n = 0;
      @(posedge clock);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 8) begin
            fail_count++;
            $display("mismatch at %0t: bus wait timed out", $time);
            test_done();
         end
         @(posedge clock);
      end
   endtask

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy();
      rd = hrdata;
   endtask

   task automatic msg(input logic [3:0] c);
      @(posedge clock);
      op <= c;
      @(posedge clock);
      op <= 4'h0;
      tick(2);
   endtask

   task automatic ev(input logic [4:0] e);
      @(posedge clock);
      evt <= e;
      @(posedge clock);
      evt <= 5'h00;
      tick(2);
   endtask

   task automatic doCmd(input glrs_pkg::glrs_cmd_kind_t k, input logic ex, input logic rj);
      @(posedge clock);
      cmd <= '{start: 1'b1, kind: k};
      @(posedge clock);
      cmd.start <= 1'b0;
      #1;
      chk(cmdExecute, ex, "execute");
      chk(cmdReject, rj, "reject");
   endtask

   task automatic st(input logic [1:0] s);
      bus(1'b0, 32'h4, 32'h0);
      chk(rd[1:0], s, "state");
      chk(remote_indicator, s[1], "remote led");
      chk(hresp, 1'b0, "okay response");
   endtask

   task automatic t_regs;
      st(2'h0);
      bus(1'b0, 32'h0, 32'h0);
      chk(rd, 32'h0001_1900, "ctrl reset");
      bus(1'b0, 32'hC, 32'h0);
      chk(rd, 32'h0, "unmapped");
      bus(1'b1, 32'h0, 32'h0000_0500);
      tick(1);
      chk(busAddress, 5'h05, "address write");
      @(posedge clock);
      nvramFail <= 1'b1;
      @(posedge clock);
      nvramFail <= 1'b0;
      tick(2);
      chk(busAddress, 5'h19, "address default");
      chk(eoiOnly, 1'b1, "eoi default");
      $display("test registers done");
   endtask

   task automatic t_local;
      doCmd(glrs_pkg::CMD_QUERY, 1'b1, 1'b0);
      doCmd(glrs_pkg::CMD_SETTING, 1'b0, 1'b1);
      doCmd(glrs_pkg::CMD_OPERATIONAL, 1'b0, 1'b1);
      tick(2);
      chk(errorDisplay, 1'b1, "error shown");
      chk(poll_status_byte, 8'h62, "settings error");
      @(posedge clock);
      procBusy <= 1'b1;
      panelButton <= 1'b1;
      @(posedge clock);
      panelButton <= 1'b0;
      tick(2);
      chk(errorDisplay, 1'b0, "error cleared");
      chk(poll_status_byte, 8'h72, "busy flag");
      @(posedge clock);
      procBusy <= 1'b0;
      msg(4'h4);
      chk(poll_status_byte, 8'h00, "stack cleared");
      $display("test local done");
   endtask

   task automatic t_remote;
      @(posedge clock);
      renLevel <= 1'b1;
      tick(4);
      st(2'h2);
      doCmd(glrs_pkg::CMD_SETTING, 1'b1, 1'b0);
      @(posedge clock);
      panelDisplayPress <= 1'b1;
      @(posedge clock);
      panelDisplayPress <= 1'b0;
      st(2'h2);
      msg(4'h1);
      st(2'h2);
      doCmd(glrs_pkg::CMD_QUERY, 1'b1, 1'b0);
      st(2'h3);
      @(posedge clock);
      panelLocalReq <= 1'b1;
      adLevel <= 2'h1;
      tick(3);
      st(2'h3);
      chk(bus_addressed_indicator, 1'b1, "listen led");
      @(posedge clock);
      panelLocalReq <= 1'b0;
      msg(4'h2);
      st(2'h1);
      msg(4'h3);
      st(2'h3);
      @(posedge clock);
      adLevel <= 2'h2;
      renLevel <= 1'b0;
      doCmd(glrs_pkg::CMD_SETTING, 1'b1, 1'b0);
      tick(3);
      st(2'h0);
      chk(bus_addressed_indicator, 1'b1, "talk led");
      chk(busAddress, 5'h19, "settings kept");
      @(posedge clock);
      adLevel <= 2'h0;
      tick(3);
      chk(bus_addressed_indicator, 1'b0, "led off");
      $display("test remote done");
   endtask

   task automatic t_panel;
      @(posedge clock);
      renLevel <= 1'b1;
      cmdsPending <= 1'b1;
      tick(4);
      st(2'h2);
      @(posedge clock);
      panelLocalReq <= 1'b1;
      tick(3);
      st(2'h0);
      chk(poll_status_byte, 8'h62, "pending error");
      @(posedge clock);
      panelLocalReq <= 1'b0;
      cmdsPending <= 1'b0;
      renLevel <= 1'b0;
      msg(4'h4);
      $display("test panel done");
   endtask

   task automatic t_events;
      logic [7:0] sb[4] = '{8'h43, 8'h61, 8'h62, 8'h63};
      logic [15:0] eq[4] = '{16'h0193, 16'h0065, 16'h00CD, 16'h012E};
      for (int i = 0; i < 4; i++) begin
         ev(5'h08 >> i);
         chk(poll_status_byte, sb[i], "class code");
         chk(serviceRequest, 1'b0, "request off");
         msg(4'h6);
         chk(eventCode, eq[i], "query code");
         chk(poll_status_byte, 8'h00, "popped");
      end
      bus(1'b1, 32'h0, 32'h0001_1901);
      ev(5'h01);
      ev(5'h04);
      chk(poll_status_byte, 8'h61, "stack head");
      chk(serviceRequest, 1'b1, "request on");
      msg(4'h5);
      chk(poll_status_byte, 8'h63, "next head");
      ev(5'h10);
      chk(poll_status_byte, 8'h41, "power up");
      msg(4'h4);
      chk(poll_status_byte, 8'h41, "power up kept");
      chk(serviceRequest, 1'b1, "power up request");
      msg(4'h6);
      chk(eventCode, 16'h0191, "power code");
      chk(poll_status_byte, 8'h00, "all empty");
      $display("test events done");
   endtask

   initial begin
      rst_b = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      op = 4'h0;
      renLevel = 1'b0;
      adLevel = 2'h0;
      cmd = '{start: 1'b0, kind: glrs_pkg::CMD_QUERY};
      evt = 5'h00;
      {cmdsPending, procBusy, panelLocalReq, panelDisplayPress, panelButton, nvramFail} = 6'h00;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      t_regs();
      t_local();
      t_remote();
      t_panel();
      t_events();
      test_done();
   end
endmodule // glrs_top_bench
